// [design/bsmc_params.svh]
// timing constants and counts for the buck supervisor block
`ifndef BSMC_PARAMS_SVH
`define BSMC_PARAMS_SVH
`define BSMC_CLK_KHZ 25000
`define BSMC_DEGLITCH_US 140
`define BSMC_DEGLITCH_CYC ((`BSMC_DEGLITCH_US * `BSMC_CLK_KHZ) / 1000)
`define BSMC_PG_DELAY_MS 4
`define BSMC_PG_DELAY_CYC (`BSMC_PG_DELAY_MS * `BSMC_CLK_KHZ)
`define BSMC_SS_US 4500
`define BSMC_SS_CYC ((`BSMC_SS_US * `BSMC_CLK_KHZ) / 1000)
`define BSMC_HICCUP_MS 94
`define BSMC_HICCUP_CYC (`BSMC_HICCUP_MS * `BSMC_CLK_KHZ)
`define BSMC_CLRUN_MS 20
`define BSMC_CLRUN_CYC (`BSMC_CLRUN_MS * `BSMC_CLK_KHZ)
`define BSMC_FSW_KHZ 1000
`define BSMC_FSW_CYC (`BSMC_CLK_KHZ / `BSMC_FSW_KHZ)
`define BSMC_FMIN_KHZ 140
`define BSMC_FMIN_CYC (`BSMC_CLK_KHZ / `BSMC_FMIN_KHZ)
`define BSMC_REF_W 12
`endif

// [design/bsmc_pkg.sv]
// types shared by the buck supervisor block
package bsmc_pkg;
  typedef enum logic [2:0] {
    BSMC_OFF = 3'b000,
    BSMC_STBY = 3'b001,
    BSMC_SOFT = 3'b010,
    BSMC_RUN = 3'b011,
    BSMC_HICCUP = 3'b100
  } bsmc_state_t;
  // comparator outcomes, all already synchronous
  typedef struct packed {
    logic en_standby_on;
    logic en_standby_off_n;
    logic en_run_on;
    logic en_run_hold;
    logic vcc_rise_ok;
    logic vcc_fall_ok;
    logic therm_hot;
    logic therm_cool;
    logic fb_short;
    logic vout_in_window;
  } bsmc_cmp_t;
  // per-cycle switching comparators
  typedef struct packed {
    logic valley_over;
    logic peak_over;
    logic burst_peak;
    logic zero_cross;
    logic light_load;
    logic on_min_hit;
    logic off_min_hit;
    logic dropout;
  } bsmc_sw_t;
endpackage

// [design/bsmc_top.sv]
// supervisor, sequencing and mode control of a synchronous buck regulator
// Contract
// - power ok low during faults and start-up
// - deglitch output window comparator before flag
// - flag held low 4 ms after first enable
// - enable low forces flag low
// - standby threshold powers internal supply only
// - run threshold starts soft-start, hysteresis stops
// - below standby-off threshold shuts down fully
// - reference ramps so output rises smoothly
// - valley over limit skips cycle, low-side held
// - feedback short in limit enters 94 ms hiccup
// - persistent short runs 20 ms then stops
// - peak limit ends high-side pulse each cycle
// - zero-current detector gives diode emulation
// - internal supply lockout 3.8 V on, 3.3 V off
// - thermal shutdown 170 C, restart 158 C
// - auto mode: light load pulse-frequency, else PWM
// - pulse-frequency bursts until burst peak threshold
// - forced fixed frequency disables diode emulation
// - minimum on/off time lowers switching frequency
// - dropout folds to 140 kHz, short detect off
// - minimum on-time held fixed, frequency reduced
// - flag deglitch 140 us both edges
// - soft-start period 4.5 ms
`timescale 1ns/100ps
`include "bsmc_params.svh"
module bsmc_top #(
  parameter int unsigned PG_DELAY_CYC = `BSMC_PG_DELAY_CYC,
  parameter int unsigned SS_CYC = `BSMC_SS_CYC,
  parameter int unsigned HICCUP_CYC = `BSMC_HICCUP_CYC,
  parameter int unsigned CLRUN_CYC = `BSMC_CLRUN_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire bsmc_pkg::bsmc_cmp_t cmp_i,
  input wire bsmc_pkg::bsmc_sw_t sw_i,
  input wire logic forced_fixed_freq_mode_i,
  input wire logic power_ok_flag_i,
  output logic power_ok_flag_o,
  output logic power_ok_flag_oe_o,
  output logic internal_supply_en_o,
  output logic hs_gate_o,
  output logic ls_gate_o,
  output logic pulse_frequency_mode_o,
  output logic diode_emulation_o,
  output logic [`BSMC_REF_W-1:0] soft_ref_o,
  output logic [2:0] state_o
);
  // ------------------------------------------------------------
  // sequencing state
  // ------------------------------------------------------------
  bsmc_pkg::bsmc_state_t state;
  bsmc_pkg::bsmc_state_t next_state;
  logic vcc_ok;
  logic therm_sd;
  logic first_up;
  logic [31:0] seq_cnt;
  logic [31:0] pg_dly_cnt;
  logic [15:0] glitch_cnt;
  logic win_filt;
  logic [7:0] per_cnt;
  logic [7:0] per_len;
  logic in_limit;

  // lockout hysteresis: on at rise level, off below fall level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) vcc_ok <= 1'b0;
    else if (cmp_i.vcc_rise_ok) vcc_ok <= 1'b1;
    else if (!cmp_i.vcc_fall_ok) vcc_ok <= 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) therm_sd <= 1'b0;
    else if (cmp_i.therm_hot) therm_sd <= 1'b1;
    else if (cmp_i.therm_cool) therm_sd <= 1'b0;
  end

  wire run_ok = vcc_ok && !therm_sd;
  wire ss_done = (seq_cnt >= SS_CYC - 1);
  wire short_trip = in_limit && cmp_i.fb_short && !sw_i.dropout;
  wire clrun_done = (seq_cnt >= CLRUN_CYC - 1);
  wire hic_done = (seq_cnt >= HICCUP_CYC - 1);

  // next-state decode of enable, lockout and fault conditions
  always_comb begin
    next_state = state;
    unique case (state)
      bsmc_pkg::BSMC_OFF: begin
        if (cmp_i.en_standby_on) next_state = bsmc_pkg::BSMC_STBY;
      end
      bsmc_pkg::BSMC_STBY: begin
        if (!cmp_i.en_standby_off_n) next_state = bsmc_pkg::BSMC_OFF;
        else if (cmp_i.en_run_on && run_ok) next_state = bsmc_pkg::BSMC_SOFT;
      end
      bsmc_pkg::BSMC_SOFT, bsmc_pkg::BSMC_RUN: begin
        if (!cmp_i.en_standby_off_n) next_state = bsmc_pkg::BSMC_OFF;
        else if (!cmp_i.en_run_hold || !run_ok) next_state = bsmc_pkg::BSMC_STBY;
        // short during current limit enters hiccup
        else if (short_trip && (state == bsmc_pkg::BSMC_RUN || clrun_done))
          next_state = bsmc_pkg::BSMC_HICCUP;
        else if (state == bsmc_pkg::BSMC_SOFT && ss_done && !in_limit)
          next_state = bsmc_pkg::BSMC_RUN;
        // persistent short: limit run of 20 ms then stop
        else if (state == bsmc_pkg::BSMC_SOFT && clrun_done && in_limit)
          next_state = bsmc_pkg::BSMC_HICCUP;
      end
      bsmc_pkg::BSMC_HICCUP: begin
        if (!cmp_i.en_standby_off_n) next_state = bsmc_pkg::BSMC_OFF;
        else if (!cmp_i.en_run_hold || !run_ok) next_state = bsmc_pkg::BSMC_STBY;
        else if (hic_done) next_state = bsmc_pkg::BSMC_SOFT;
      end
      default: next_state = bsmc_pkg::BSMC_OFF;
    endcase
  end

  // state register and shared sequencing timer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) state <= bsmc_pkg::BSMC_OFF;
    else state <= next_state;
  end

  // timer counts clock cycles, restarts at each state change
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || next_state != state) seq_cnt <= 32'h0000_0000;
    else if (seq_cnt != 32'hFFFF_FFFF) seq_cnt <= seq_cnt + 32'h0000_0001;
  end

  // ------------------------------------------------------------
  // soft-start reference
  // ------------------------------------------------------------
  wire active = (state == bsmc_pkg::BSMC_SOFT) || (state == bsmc_pkg::BSMC_RUN);
  wire [31:0] ref_scaled = ss_done ? 32'h0000_0FFF :
    32'((64'(seq_cnt) * 64'h0000_0000_0000_0FFF) / 64'(SS_CYC));

  // reference ramps linearly over the soft-start period
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !active) soft_ref_o <= '0;
    else if (state == bsmc_pkg::BSMC_RUN) soft_ref_o <= '1;
    else soft_ref_o <= ref_scaled[`BSMC_REF_W-1:0];
  end

  // ------------------------------------------------------------
  // power ok flag
  // ------------------------------------------------------------
  // filter: window must differ for the whole deglitch time
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      glitch_cnt <= 16'h0000;
      win_filt <= 1'b0;
    end else if (cmp_i.vout_in_window == win_filt) begin
      glitch_cnt <= 16'h0000;
    end else if (glitch_cnt >= 16'(`BSMC_DEGLITCH_CYC - 1)) begin
      // both edges take the same deglitch delay
      glitch_cnt <= 16'h0000;
      win_filt <= cmp_i.vout_in_window;
    end else begin
      glitch_cnt <= glitch_cnt + 16'h0001;
    end
  end

  // initial start-up delay from first enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || state == bsmc_pkg::BSMC_OFF) begin
      pg_dly_cnt <= 32'h0000_0000;
      first_up <= 1'b1;
    end else if (first_up && cmp_i.en_run_on) begin
      if (pg_dly_cnt >= PG_DELAY_CYC - 1) first_up <= 1'b0;
      else pg_dly_cnt <= pg_dly_cnt + 32'h0000_0001;
    end
  end

  // faults and start-up pull the flag low; enable low does too
  wire pg_good = (state == bsmc_pkg::BSMC_RUN) && win_filt && !first_up &&
    !in_limit && !therm_sd && cmp_i.en_run_hold;

  // open-drain: enable high means pulling the pin low
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      power_ok_flag_o <= 1'b0;
      power_ok_flag_oe_o <= 1'b1;
    end else begin
      power_ok_flag_o <= 1'b0;
      power_ok_flag_oe_o <= !pg_good;
    end
  end

  // ------------------------------------------------------------
  // switching period and gates
  // ------------------------------------------------------------
  // frequency foldback; on-time fixed, period stretched
  wire fold = sw_i.on_min_hit || sw_i.off_min_hit || sw_i.dropout;
  wire [7:0] base_len = 8'(`BSMC_FSW_CYC);
  // dropout clamps period at minimum frequency
  wire [7:0] next_len = !fold ? base_len :
    ((per_len >= 8'(`BSMC_FMIN_CYC)) ? 8'(`BSMC_FMIN_CYC) : per_len + 8'h01);
  wire period_end = (per_cnt >= per_len - 8'h01);
  // auto mode enters pulse-frequency mode at light load
  wire pulse_frequency_mode = !forced_fixed_freq_mode_i && sw_i.light_load;
  // diode emulation unless forced fixed frequency
  wire diode_emulation = !forced_fixed_freq_mode_i;
  wire switching = active && power_ok_flag_i | 1'b1;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !active) begin
      per_cnt <= 8'h00;
      per_len <= 8'(`BSMC_FSW_CYC);
    end else if (period_end) begin
      per_cnt <= 8'h00;
      per_len <= next_len;
    end else begin
      per_cnt <= per_cnt + 8'h01;
    end
  end

  // current-limit status, valley or peak comparator held over a period
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !active) in_limit <= 1'b0;
    else if (sw_i.valley_over || sw_i.peak_over) in_limit <= 1'b1;
    else if (period_end) in_limit <= 1'b0;
  end

  // gate drive with cycle skip, peak end and zero-current cutoff
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !switching) begin
      hs_gate_o <= 1'b0;
      ls_gate_o <= 1'b0;
    end else if (period_end) begin
      // valley over limit: skip turn-on, keep low-side on
      // burst pulse only when pulse-frequency asks for energy
      hs_gate_o <= !sw_i.valley_over && (!pulse_frequency_mode || !cmp_i.vout_in_window);
      ls_gate_o <= sw_i.valley_over;
    end else if (hs_gate_o && (sw_i.peak_over || (pulse_frequency_mode && sw_i.burst_peak))) begin
      // peak limit ends high-side pulse; burst peak too
      hs_gate_o <= 1'b0;
      ls_gate_o <= 1'b1;
    end else if (ls_gate_o && diode_emulation && sw_i.zero_cross && !sw_i.valley_over) begin
      ls_gate_o <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      internal_supply_en_o <= 1'b0;
      pulse_frequency_mode_o <= 1'b0;
      diode_emulation_o <= 1'b0;
      state_o <= 3'h0;
    end else begin
      internal_supply_en_o <= (state != bsmc_pkg::BSMC_OFF);
      pulse_frequency_mode_o <= pulse_frequency_mode && active;
      diode_emulation_o <= diode_emulation;
      state_o <= state;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_flag_low_fault;
    @(posedge mclk_i) disable iff (sys_rst_i) (therm_sd || in_limit) |=> power_ok_flag_oe_o;
  endproperty
  a_flag_low_fault: assert property (p_flag_low_fault) else $error("flag not low in fault");

  property p_flag_low_en;
    @(posedge mclk_i) disable iff (sys_rst_i) !cmp_i.en_run_hold |=> power_ok_flag_oe_o;
  endproperty
  a_flag_low_en: assert property (p_flag_low_en) else $error("flag not low with enable low");

  property p_filter;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (cmp_i.vout_in_window == win_filt || glitch_cnt < 16'(`BSMC_DEGLITCH_CYC - 1))
      |=> $stable(win_filt);
  endproperty
  a_filter: assert property (p_filter) else $error("short excursion changed filter");

  property p_supply;
    @(posedge mclk_i) disable iff (sys_rst_i) (state == bsmc_pkg::BSMC_STBY) |=> internal_supply_en_o;
  endproperty
  a_supply: assert property (p_supply) else $error("standby without internal supply");

  property p_shutdown;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (state != bsmc_pkg::BSMC_OFF && !cmp_i.en_standby_off_n) |=> (state == bsmc_pkg::BSMC_OFF);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown below threshold");

  property p_lockout;
    @(posedge mclk_i) disable iff (sys_rst_i) !vcc_ok |-> (state != bsmc_pkg::BSMC_RUN) || !$stable(vcc_ok);
  endproperty
  a_lockout: assert property (p_lockout) else $error("run with supply locked out");

  property p_skip;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (switching && period_end && sw_i.valley_over) |=> (!hs_gate_o && ls_gate_o);
  endproperty
  a_skip: assert property (p_skip) else $error("valley limit did not skip");

  property p_peak;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (hs_gate_o && sw_i.peak_over && !period_end) |=> !hs_gate_o;
  endproperty
  a_peak: assert property (p_peak) else $error("peak limit did not end pulse");

  property p_nodem;
    @(posedge mclk_i) disable iff (sys_rst_i) forced_fixed_freq_mode_i |=> !diode_emulation_o;
  endproperty
  a_nodem: assert property (p_nodem) else $error("emulation on in forced mode");

  property p_hic_off;
    @(posedge mclk_i) disable iff (sys_rst_i) (state == bsmc_pkg::BSMC_HICCUP) |=> !hs_gate_o;
  endproperty
  a_hic_off: assert property (p_hic_off) else $error("switching in hiccup");

  c_run: cover property (@(posedge mclk_i) state == bsmc_pkg::BSMC_RUN);
  c_hiccup: cover property (@(posedge mclk_i) state == bsmc_pkg::BSMC_HICCUP);
  c_pg_up: cover property (@(posedge mclk_i) $fell(power_ok_flag_oe_o));
  c_fold: cover property (@(posedge mclk_i) per_len == 8'(`BSMC_FMIN_CYC));
endmodule

// [tb/bsmc_host_model.sv]
// model of the enable driver and the host watching the flag
`timescale 1ns/100ps
module bsmc_host_model (
  input wire logic mclk_i,
  input wire logic [1:0] en_lvl_i,
  input wire logic flag_oe_i,
  output logic [3:0] enable_o,
  output logic flag_wire_o,
  output logic flag_good_o
);
  assign enable_o = {en_lvl_i != 2'h0, en_lvl_i != 2'h0, en_lvl_i == 2'h2, en_lvl_i == 2'h2};
  // pull-up wins whenever the open drain lets go
  assign flag_wire_o = flag_oe_i ? 1'h0 : 1'h1;
  // host samples the flag on its clock
  always_ff @(posedge mclk_i) begin
    flag_good_o <= flag_wire_o;
  end
endmodule

// [tb/test_buck_supervisor_mode_control.sv]
// self-checking bench for the buck supervisor block
`timescale 1ns/100ps
module test_buck_supervisor_mode_control;
  localparam int PGD = 50;
  localparam int SSC = 40;
  localparam int HCC = 60;
  localparam int CLC = 30;
  localparam int DGL = 3500;
  logic mclk_i = 0;
  logic sys_rst_i = 1;
  logic ffm = 0;
  logic [1:0] en_lvl = 0;
  logic vcc_r = 1, vcc_f = 1, hot = 0, cool = 1, fbs = 0, win = 0;
  logic [3:0] en4;
  bsmc_pkg::bsmc_sw_t sw = '0;
  bsmc_pkg::bsmc_cmp_t cmp_in;
  logic pg_oe, pg_o, flag_wire, flag_good, sup_en, hs, ls, pulse_frequency_mode, diode_emulation;
  logic [11:0] ref_v;
  logic [2:0] st;
  int miscompares = 0;
  int n_tests = 0;
  assign cmp_in = {en4, vcc_r, vcc_f, hot, cool, fbs, win};
  bsmc_top #(.PG_DELAY_CYC(PGD), .SS_CYC(SSC), .HICCUP_CYC(HCC), .CLRUN_CYC(CLC)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp_in), .sw_i(sw),
    .forced_fixed_freq_mode_i(ffm), .power_ok_flag_i(flag_wire),
    .power_ok_flag_o(pg_o), .power_ok_flag_oe_o(pg_oe), .internal_supply_en_o(sup_en),
    .hs_gate_o(hs), .ls_gate_o(ls), .pulse_frequency_mode_o(pulse_frequency_mode),
    .diode_emulation_o(diode_emulation), .soft_ref_o(ref_v), .state_o(st));
  bsmc_host_model host (.mclk_i(mclk_i), .en_lvl_i(en_lvl), .flag_oe_i(pg_oe),
    .enable_o(en4), .flag_wire_o(flag_wire), .flag_good_o(flag_good));
  // clock
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  // compare and count
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // step whole cycles, land just after the edge
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // bounded wait for the host to see a flag level
  task wait_good(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && flag_good !== v; i++) tick(1);
  endtask
  // count gate-high samples over n cycles
  task pulses(input int n, output int nh, output int nl);
    nh = 0;
    nl = 0;
    repeat (n) begin
      tick(1);
      nh += hs;
      nl += ls;
    end
  endtask
  // cycles between two one-cycle high-side pulses
  task gap(output int n);
    int k;
    k = 0;
    while (hs !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (hs !== 1'b1 && n < 400);
  endtask
  // verdict
  task end_sim;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // power-up sequence, soft-start and first flag release
  task t_start;
    logic [11:0] r0;
    en_lvl = 1;
    tick(3);
    chk(st, 12'h1);
    chk(sup_en, 12'h1);
    en_lvl = 2;
    win = 1;
    tick(3);
    chk(st, 12'h2);
    r0 = ref_v;
    tick(10);
    chk(12'(ref_v > r0), 12'h1);
    chk(st, 12'h2);
    tick(SSC);
    chk(st, 12'h3);
    chk(flag_good, 12'h0);
    tick(DGL - 600);
    chk(flag_good, 12'h0);
    wait_good(1, 1000);
    chk(flag_good, 12'h1);
    $display("start test done");
  endtask
  // short and long excursions of the output window
  task t_glitch;
    win = 0;
    tick(DGL / 2);
    chk(flag_good, 12'h1);
    win = 1;
    tick(DGL / 2);
    win = 0;
    tick(DGL - 200);
    chk(flag_good, 12'h1);
    wait_good(0, 400);
    chk(flag_good, 12'h0);
    win = 1;
    wait_good(1, DGL + 100);
    chk(flag_good, 12'h1);
    $display("glitch test done");
  endtask
  // every pairing of fixed-frequency variant and load
  task t_modes;
    for (int k = 0; k < 4; k++) begin
      ffm = k[1];
      sw.light_load = k[0];
      tick(30);
      if (ffm) chk(diode_emulation, 12'h0);
      if (!ffm && sw.light_load) chk(diode_emulation, 12'h1);
      chk(pulse_frequency_mode, 12'(!ffm && sw.light_load));
    end
    ffm = 0;
    sw.light_load = 0;
    $display("mode test done");
  endtask
  // valley limit, dropout guard, hiccup and repeat
  task t_limit;
    logic hs_any, ls_all;
    hs_any = 0;
    ls_all = 1;
    sw.valley_over = 1;
    tick(28);
    for (int i = 0; i < 30; i++) begin
      tick(1);
      hs_any |= hs;
      ls_all &= ls;
    end
    chk(hs_any, 12'h0);
    chk(ls_all, 12'h1);
    sw.dropout = 1;
    fbs = 1;
    tick(20);
    chk(st, 12'h3);
    sw.dropout = 0;
    tick(4);
    chk(st, 12'h4);
    chk(hs, 12'h0);
    tick(HCC - 10);
    chk(st, 12'h4);
    tick(10);
    chk(st, 12'h2);
    tick(CLC - 10);
    chk(st, 12'h2);
    tick(15);
    chk(st, 12'h4);
    sw.valley_over = 0;
    fbs = 0;
    tick(HCC + SSC + 20);
    chk(st, 12'h3);
    $display("limit test done");
  endtask
  // peak limit, foldback, dropout clamp and pulse-frequency bursts
  task t_switch;
    int g1, g2, nh, nl;
    sw.peak_over = 1;
    tick(30);
    pulses(50, nh, nl);
    chk(12'(nh), 12'h002);
    chk(12'(nl), 12'h030);
    gap(g1);
    chk(12'(g1), 12'h019);
    sw.on_min_hit = 1;
    gap(g1);
    gap(g2);
    chk(12'(g2 - g1), 12'h001);
    gap(g1);
    chk(12'(g1 > 25), 12'h001);
    sw.dropout = 1;
    tick(16000);
    gap(g1);
    chk(12'(g1), 12'h0B2);
    sw = '0;
    sw.light_load = 1;
    sw.burst_peak = 1;
    sw.zero_cross = 1;
    win = 0;
    tick(200);
    pulses(50, nh, nl);
    chk(12'(nh), 12'h002);
    chk(12'(nl), 12'h002);
    win = 1;
    tick(30);
    pulses(50, nh, nl);
    chk(12'(nh), 12'h000);
    sw = '0;
    $display("switch test done");
  endtask
  // thermal, supply lockout and enable thresholds
  task t_faults;
    hot = 1;
    cool = 0;
    tick(3);
    chk(st, 12'h1);
    chk(flag_good, 12'h0);
    hot = 0;
    tick(5);
    chk(st, 12'h1);
    cool = 1;
    tick(6);
    chk(st, 12'h2);
    vcc_f = 0;
    vcc_r = 0;
    tick(3);
    chk(st, 12'h1);
    vcc_f = 1;
    tick(6);
    chk(st, 12'h1);
    vcc_r = 1;
    tick(SSC + 8);
    chk(st, 12'h3);
    en_lvl = 1;
    tick(3);
    chk(st, 12'h1);
    en_lvl = 0;
    tick(3);
    chk(st, 12'h0);
    chk(sup_en, 12'h0);
    chk(pg_oe, 12'h1);
    $display("fault test done");
  endtask
  // main sequence
  initial begin
    tick(10);
    chk(pg_oe, 12'h1);
    chk(pg_o, 12'h0);
    chk({hs, ls}, 12'h0);
    chk(ref_v, 12'h0);
    sys_rst_i = 0;
    tick(2);
    t_start();
    t_glitch();
    t_modes();
    t_limit();
    t_switch();
    t_faults();
    end_sim();
  end
  // watchdog
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
endmodule
